//--- verilog/tw_pkg.sv
// Shared constants and types for the three-timer block with watchdog
// Summary of operation
// - Three independent 32-bit programmable timers, each usable as general-purpose timer.
// - Third timer runs general-purpose, watchdog, or both; others general-purpose only.
// - A 13-bit prescaler per timer divides the clock to give that timer's reference tick.
// - Each counter counts down from its start value once per reference tick.
// - On expiry raise interrupt; auto-reload restarts the count, otherwise the timer stops.
// - Watchdog role uses a 16-bit counter behind a 16-bit prescaler.
// - Watchdog expiry pulses the reset output low; ordinary timers never do.
// - One combined interrupt, routed as ordinary timer interrupt or non-maskable interrupt.
// - A separate sticky flag per timer shows which timer fired.
// - The timer interrupt also appears as a DMA event.
package tw_pkg;
    localparam int TW_NUM    = 3;
    localparam int TW_CNT_W  = 32;
    localparam int TW_PRE_W  = 13;
    localparam int TW_WD_W   = 16;
    localparam int TW_WD_IDX = 2;

    localparam int CLK_NS          = 10;
    localparam int WD_PULSE_NS     = 100;
    localparam int WD_PULSE_CYC    = (WD_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] WD_PULSE_CNT = 8'(WD_PULSE_CYC);

    localparam logic [TW_CNT_W-1:0] CNT_RST = 32'h0000_0000;
    localparam logic [TW_PRE_W-1:0] PRE_RST = 13'h0000;
    localparam logic [TW_PRE_W-1:0] PRE_ONE = 13'h0001;
    localparam logic [TW_CNT_W-1:0] CNT_ONE = 32'h0000_0001;
    localparam logic [TW_WD_W-1:0]  WD_RST  = 16'h0000;
    localparam logic [TW_WD_W-1:0]  WD_ONE  = 16'h0001;

    // Encoding of the third timer's role selection
    typedef enum logic [1:0] {
        TW_ROLE_GP,
        TW_ROLE_WD,
        TW_ROLE_BOTH
    } tw_role_t;

    typedef enum logic [1:0] {
        WD_OFF,
        WD_RUN,
        WD_FIRE
    } tw_wd_state_t;

    typedef struct packed {
        logic [TW_CNT_W-1:0] load_val;
        logic [TW_PRE_W-1:0] prescale;
        logic                auto_reload;
    } tw_cfg_t;

    typedef struct packed {
        logic [TW_WD_W-1:0] load_val;
        logic [TW_WD_W-1:0] prescale;
    } tw_wd_cfg_t;
endpackage

//--- verilog/tw_timer_trio.sv
// Three down-counting timers, third one doubling as watchdog, with combined interrupt
`timescale 1ns/1ps
module tw_timer_trio (
    input  wire logic                         clock,        // 100 MHz clock
    input  wire logic                         rst,          // Async reset, active high
    input  wire tw_pkg::tw_cfg_t [2:0]        cfg,          // Per-timer configuration
    input  wire logic [2:0]                   start,        // Pulse: load and run timer
    input  wire logic [2:0]                   stop,         // Pulse: halt timer
    input  wire tw_pkg::tw_role_t             role,         // Third timer role
    input  wire tw_pkg::tw_wd_cfg_t           wd_cfg,       // Watchdog reload and prescale
    input  wire logic                         wd_enable,    // Pulse: arm watchdog
    input  wire logic                         wd_service,   // Pulse: reload watchdog
    input  wire logic                         nmi_select,   // 1 routes interrupt to nmi
    input  wire logic [2:0]                   flag_clear,   // Pulse: clear per-timer flag
    output wire logic [2:0][31:0]             count,        // Current counter values
    output wire logic [2:0]                   running,      // Timer running
    output wire logic [2:0]                   flags,        // Sticky expiry flags
    output wire logic                         timer_interrupt_route, // Ordinary interrupt
    output wire logic                         nmi,          // Non-maskable interrupt
    output wire logic                         dma_event,    // One-cycle DMA trigger
    output wire logic                         wd_reset_n,   // Watchdog reset, active low
    output wire logic [15:0]                  wd_count      // Watchdog counter value
);
    logic [tw_pkg::TW_CNT_W-1:0] cnt_q [3];
    logic [tw_pkg::TW_PRE_W-1:0] pre_q [3];
    logic [2:0]                  run_q;
    logic [2:0]                  tick;
    logic [2:0]                  zero;
    logic [2:0]                  expire;
    logic [2:0]                  gp_ok;
    logic [2:0]                  flags_q;
    logic [2:0]                  flags_d;
    logic                        irq_d;
    logic                        timer_interrupt_route_q;
    logic                        nmi_q;
    logic                        dma_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    genvar i;
    generate
        for (i = 0; i < tw_pkg::TW_NUM; i++) begin : g_tmr
            // Third timer loses its general-purpose role in watchdog-only mode
            assign gp_ok[i] = (i != tw_pkg::TW_WD_IDX) || (role != tw_pkg::TW_ROLE_WD);
            // Prescaler divides by prescale plus one
            assign tick[i]   = run_q[i] && (pre_q[i] == cfg[i].prescale);
            assign zero[i]   = (cnt_q[i] == tw_pkg::CNT_RST);
            assign expire[i] = tick[i] && zero[i] && gp_ok[i];
            assign count[i]  = cnt_q[i];

            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    cnt_q[i] <= tw_pkg::CNT_RST;
                    pre_q[i] <= tw_pkg::PRE_RST;
                    run_q[i] <= 1'b0;
                end else if (start[i] && gp_ok[i]) begin
                    cnt_q[i] <= cfg[i].load_val;
                    pre_q[i] <= tw_pkg::PRE_RST;
                    run_q[i] <= 1'b1;
                end else if (stop[i] || !gp_ok[i]) begin
                    run_q[i] <= 1'b0;
                end else if (run_q[i]) begin
                    pre_q[i] <= tick[i] ? tw_pkg::PRE_RST : pre_q[i] + tw_pkg::PRE_ONE;
                    if (tick[i] && !zero[i]) begin
                        cnt_q[i] <= cnt_q[i] - tw_pkg::CNT_ONE;
                    end else if (tick[i] && cfg[i].auto_reload) begin
                        cnt_q[i] <= cfg[i].load_val;
                    end else if (tick[i]) begin
                        run_q[i] <= 1'b0;
                    end
                end
            end

            a_gp_count_down: assert property (
                tick[i] && !zero[i] && !start[i] && !stop[i] && gp_ok[i]
                |=> cnt_q[i] == $past(cnt_q[i]) - tw_pkg::CNT_ONE)
                else $error("timer did not decrement on tick");
            a_gp_auto_reload: assert property (
                expire[i] && cfg[i].auto_reload && !start[i] && !stop[i]
                |=> run_q[i] && cnt_q[i] == $past(cfg[i].load_val))
                else $error("timer did not reload on expiry");
            a_gp_one_shot: assert property (
                expire[i] && !cfg[i].auto_reload && !start[i]
                |=> !run_q[i])
                else $error("one-shot timer kept running");
            a_flag_on_expire: assert property (expire[i] |=> flags_q[i] ##1 1'b1)
                else $error("expiry flag not latched");
            a_pre_divide: assert property (
                tick[i] && !start[i] && !stop[i] && cfg[i].prescale != tw_pkg::PRE_RST
                && $stable(cfg[i].prescale) |=> !tick[i])
                else $error("prescaler ticked twice in a row");

            // Prescaler steps by one between ticks
            a_pre_count: assert property (
                run_q[i] && !tick[i] && !start[i] && !stop[i] && gp_ok[i]
                |=> pre_q[i] == $past(pre_q[i]) + tw_pkg::PRE_ONE)
                else $error("prescaler did not advance");

            // Count only moves on a tick or a start
            a_count_hold: assert property (
                !tick[i] && !(start[i] && gp_ok[i]) |=> $stable(cnt_q[i]))
                else $error("counter moved without a tick");

            a_start_load: assert property (
                start[i] && gp_ok[i] |=> run_q[i] && cnt_q[i] == $past(cfg[i].load_val))
                else $error("start did not load the timer");

            a_stop_halt: assert property (stop[i] && !start[i] |=> !run_q[i])
                else $error("stop did not halt the timer");

            // Timer without general role stays halted
            a_role_halt: assert property (!gp_ok[i] |=> !run_q[i])
                else $error("timer ran outside its role");

            a_flag_hold: assert property (flags_q[i] && !flag_clear[i] |=> flags_q[i])
                else $error("flag dropped without clear");

            a_flag_cause: assert property (!flags_q[i] && !expire[i] |=> !flags_q[i])
                else $error("flag set without expiry");
        end
    endgenerate

    // Sticky flags, a new expiry beats a clear in the same cycle
    assign flags_d = (flags_q & ~flag_clear) | expire;
    assign irq_d   = |flags_d;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flags_q <= 3'h0;
            timer_interrupt_route_q  <= 1'b0;
            nmi_q   <= 1'b0;
            dma_q   <= 1'b0;
        end else begin
            flags_q <= flags_d;
            // Route to ordinary or non-maskable line
            timer_interrupt_route_q  <= irq_d && !nmi_select;
            nmi_q   <= irq_d && nmi_select;
            dma_q   <= |expire;
        end
    end

    assign running               = run_q;
    assign flags                 = flags_q;
    assign timer_interrupt_route = timer_interrupt_route_q;
    assign nmi                   = nmi_q;
    assign dma_event             = dma_q;

    // Watchdog: separate 16-bit counter so the general-purpose count stays usable in both mode
    tw_pkg::tw_wd_state_t   wd_state_q;
    logic [15:0]            wd_cnt_q;
    logic [15:0]            wd_pre_q;
    logic [7:0]             pulse_q;
    logic                   wd_rst_n_q;
    logic                   wd_allowed;
    logic                   wd_tick;
    logic                   wd_zero;

    assign wd_allowed = (role != tw_pkg::TW_ROLE_GP);
    // 16-bit prescaler gates the watchdog count
    assign wd_tick    = (wd_state_q == tw_pkg::WD_RUN) && (wd_pre_q == wd_cfg.prescale);
    assign wd_zero    = (wd_cnt_q == tw_pkg::WD_RST);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wd_state_q <= tw_pkg::WD_OFF;
            wd_cnt_q   <= tw_pkg::WD_RST;
            wd_pre_q   <= tw_pkg::WD_RST;
            pulse_q    <= 8'h00;
            wd_rst_n_q <= 1'b1;
        end else begin
            case (wd_state_q)
                tw_pkg::WD_OFF: begin
                    if (wd_enable && wd_allowed) begin
                        wd_state_q <= tw_pkg::WD_RUN;
                        wd_cnt_q   <= wd_cfg.load_val;
                        wd_pre_q   <= tw_pkg::WD_RST;
                    end
                end
                tw_pkg::WD_RUN: begin
                    if (!wd_allowed) begin
                        wd_state_q <= tw_pkg::WD_OFF;
                    end else if (wd_service) begin
                        wd_cnt_q <= wd_cfg.load_val;
                        wd_pre_q <= tw_pkg::WD_RST;
                    end else if (wd_tick && wd_zero) begin
                        wd_state_q <= tw_pkg::WD_FIRE;
                        pulse_q    <= tw_pkg::WD_PULSE_CNT;
                        wd_rst_n_q <= 1'b0;
                    end else begin
                        wd_pre_q <= wd_tick ? tw_pkg::WD_RST : wd_pre_q + tw_pkg::WD_ONE;
                        if (wd_tick) begin
                            wd_cnt_q <= wd_cnt_q - tw_pkg::WD_ONE;
                        end
                    end
                end
                tw_pkg::WD_FIRE: begin
                    // Disarmed after firing; software must re-arm after the reset
                    pulse_q <= pulse_q - 8'h01;
                    if (pulse_q == 8'h01) begin
                        wd_state_q <= tw_pkg::WD_OFF;
                        wd_rst_n_q <= 1'b1;
                    end
                end
                default: begin
                    wd_state_q <= tw_pkg::WD_OFF;
                    wd_rst_n_q <= 1'b1;
                end
            endcase
        end
    end

    assign wd_reset_n = wd_rst_n_q;
    assign wd_count   = wd_cnt_q;

    // Pulse stays low for at least its first eight cycles
    a_wd_pulse_low: assert property ($fell(wd_rst_n_q) |-> !wd_rst_n_q [*8])
        else $error("watchdog reset pulse too short");
    // Pulse ends after exactly ten cycles
    a_wd_pulse_end: assert property ($fell(wd_rst_n_q) |-> ##9 !wd_rst_n_q ##1 wd_rst_n_q)
        else $error("watchdog reset pulse wrong length");
    // Only watchdog expiry drives reset low
    a_wd_pulse_cause: assert property ($fell(wd_rst_n_q) |-> $past(wd_tick && wd_zero))
        else $error("reset pulse without watchdog expiry");
    a_wd_service: assert property (
        wd_state_q == tw_pkg::WD_RUN && wd_service && wd_allowed
        |=> wd_rst_n_q && wd_cnt_q == $past(wd_cfg.load_val))
        else $error("watchdog service did not reload");
    a_irq_route: assert property (
        ##1 (timer_interrupt_route == ((|flags_q) && !$past(nmi_select))) &&
        (nmi == ((|flags_q) && $past(nmi_select))))
        else $error("combined interrupt routed wrongly");
    // DMA event tied to an expiry
    a_dma_from_expire: assert property (dma_event |-> $past(|expire))
        else $error("dma event without expiry");
    // Clear removes a flag when no new expiry
    a_flag_clear: assert property (flag_clear[0] && !expire[0] |=> !flags_q[0])
        else $error("flag not cleared");

    // Watchdog checks, each against the watchdog's own state, then one DMA check on the timer expiries
    // Leaving the watchdog role disarms it
    a_wd_role_off: assert property (
        wd_state_q == tw_pkg::WD_RUN && !wd_allowed |=> wd_state_q == tw_pkg::WD_OFF)
        else $error("watchdog kept running in general role");

    // Arming needs the enable and a watchdog role
    a_wd_stay_off: assert property (
        wd_state_q == tw_pkg::WD_OFF && !(wd_enable && wd_allowed)
        |=> wd_state_q == tw_pkg::WD_OFF)
        else $error("watchdog armed without enable");

    a_wd_arm_load: assert property (
        wd_state_q == tw_pkg::WD_OFF && wd_enable && wd_allowed
        |=> wd_state_q == tw_pkg::WD_RUN && wd_cnt_q == $past(wd_cfg.load_val))
        else $error("watchdog not loaded when armed");

    // Watchdog counts down once per tick
    a_wd_count_down: assert property (
        wd_state_q == tw_pkg::WD_RUN && wd_allowed && !wd_service && wd_tick && !wd_zero
        |=> wd_cnt_q == $past(wd_cnt_q) - tw_pkg::WD_ONE)
        else $error("watchdog did not decrement");

    a_wd_fire: assert property (
        wd_state_q == tw_pkg::WD_RUN && wd_allowed && !wd_service && wd_tick && wd_zero
        |=> !wd_rst_n_q && wd_state_q == tw_pkg::WD_FIRE)
        else $error("watchdog expiry gave no reset pulse");

    // Every expiry gives a DMA trigger
    a_dma_on_expire: assert property ((|expire) |=> dma_event)
        else $error("expiry gave no dma event");

    // Main scenarios the bench should reach
    c_auto_reload: cover property (expire[1] && cfg[1].auto_reload ##[1:50] expire[1]);
    c_wd_serviced: cover property (wd_state_q == tw_pkg::WD_RUN && wd_service);
    c_wd_fire: cover property ($fell(wd_rst_n_q));
    c_nmi_route: cover property (nmi);
    c_both_roles: cover property (role == tw_pkg::TW_ROLE_BOTH && expire[2]);
endmodule // tw_timer_trio

//--- dv/tw_far_side.sv
// Far-side model: CPU interrupt input, DMA event input and device reset sink
`timescale 1ns/1ps
module tw_far_side (
    input  wire logic       clock,       // 100 MHz clock
    input  wire logic       rst,         // Async reset, active high
    input  wire logic       irq,         // Ordinary timer interrupt
    input  wire logic       nmi,         // Non-maskable interrupt
    input  wire logic       dma_event,   // DMA trigger pulse
    input  wire logic       wd_reset_n,  // Reset request, active low
    output logic      [7:0] int_seen,    // Interrupt arrivals
    output logic      [7:0] dma_seen,    // DMA triggers taken
    output logic      [7:0] pulses_seen, // Reset pulses seen
    output logic      [7:0] pulse_len    // Length of last reset pulse
);
    logic       int_q;
    logic       low_q;
    logic [7:0] run_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            int_q       <= 1'b0;
            low_q       <= 1'b0;
            run_q       <= 8'h00;
            int_seen    <= 8'h00;
            dma_seen    <= 8'h00;
            pulses_seen <= 8'h00;
            pulse_len   <= 8'h00;
        end else begin
            int_q <= irq | nmi;
            low_q <= ~wd_reset_n;
            if ((irq | nmi) && !int_q) int_seen <= int_seen + 8'h01;
            if (dma_event) dma_seen <= dma_seen + 8'h01;
            if (!wd_reset_n) run_q <= run_q + 8'h01;
            else if (low_q) begin
                pulse_len   <= run_q;
                pulses_seen <= pulses_seen + 8'h01;
                run_q       <= 8'h00;
            end
        end
    end
endmodule // tw_far_side

//--- dv/tb.sv
// Self-checking bench for the three-timer block and its watchdog
`timescale 1ns/1ps
module tb;
    logic                  clock, rst, wd_enable, wd_service, nmi_select;
    tw_pkg::tw_cfg_t [2:0] cfg;
    logic [2:0]            start, stop, flag_clear, running, flags;
    tw_pkg::tw_role_t      role;
    tw_pkg::tw_wd_cfg_t    wd_cfg;
    logic [2:0][31:0]      count;
    logic                  irq, nmi, dma_event, wd_reset_n;
    logic [15:0]           wd_count;
    logic [7:0]            int_seen, dma_seen, pulses_seen, pulse_len;
    int                    bad_count, n_tests, n;

    tw_timer_trio i_tw_timer_trio (.clock(clock), .rst(rst), .cfg(cfg), .start(start),
        .stop(stop), .role(role), .wd_cfg(wd_cfg), .wd_enable(wd_enable),
        .wd_service(wd_service), .nmi_select(nmi_select), .flag_clear(flag_clear),
        .count(count), .running(running), .flags(flags), .timer_interrupt_route(irq),
        .nmi(nmi), .dma_event(dma_event), .wd_reset_n(wd_reset_n), .wd_count(wd_count));
    tw_far_side i_tw_far_side (.clock(clock), .rst(rst), .irq(irq), .nmi(nmi),
        .dma_event(dma_event), .wd_reset_n(wd_reset_n), .int_seen(int_seen),
        .dma_seen(dma_seen), .pulses_seen(pulses_seen), .pulse_len(pulse_len));

    always #5 clock = ~clock;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic start_timer(input int i, input logic [31:0] ld, input logic [12:0] pre,
                               input logic ar);
        cfg[i]   = '{load_val: ld, prescale: pre, auto_reload: ar};
        start[i] = 1'b1;
        @(negedge clock);
        start[i] = 1'b0;
    endtask

    // Counts cycles from the start edge until the flag shows, bounded
    task automatic wait_flag(input int i);
        n = 1;
        while (flags[i] !== 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
    endtask

    task automatic clear_flags(input logic [2:0] m);
        flag_clear = m;
        @(negedge clock);
        flag_clear = 3'h0;
        repeat (2) @(negedge clock);
    endtask

    task automatic service(input int times);
        repeat (times) begin
            wd_service = 1'b1;
            @(negedge clock);
            wd_service = 1'b0;
            repeat (3) @(negedge clock);
        end
    endtask

    initial begin
        #50000;
        bad_count++;
        stop_test();
    end

    initial begin
        clock = 1'b0; rst = 1'b1; cfg = '0; start = 3'h0; stop = 3'h0; flag_clear = 3'h0;
        role = tw_pkg::TW_ROLE_GP; wd_cfg = '0; wd_enable = 1'b0; wd_service = 1'b0;
        nmi_select = 1'b0; bad_count = 0; n_tests = 0;
        repeat (5) @(negedge clock);
        rst = 1'b0;
        check(32'(running), 32'h0, "running after reset");
        check(32'({flags, irq, nmi, wd_reset_n}), 32'h1, "outputs after reset");
        start_timer(0, 32'h0000_0003, 13'h0001, 1'b0);
        check(count[0], 32'h0000_0003, "start value");
        wait_flag(0);
        check(32'(n), 32'h09, "expiry time with prescale");
        check(32'({flags, irq, nmi, dma_event, running[0]}), 32'h1A, "one-shot expiry");
        check(count[0], 32'h0, "counter at expiry");
        clear_flags(3'h1);
        check(32'({flags, irq}), 32'h0, "flag cleared");
        nmi_select = 1'b1;
        start_timer(1, 32'h0000_0002, 13'h0000, 1'b1);
        wait_flag(1);
        check(32'(n), 32'h04, "expiry time no prescale");
        check(32'({flags, irq, nmi, running[1]}), 32'h13, "routed as nmi, reloaded");
        clear_flags(3'h2);
        wait_flag(1);
        check(32'(flags), 32'h2, "periodic expiry");
        stop[1] = 1'b1;
        @(negedge clock);
        stop[1] = 1'b0;
        check(32'(running), 32'h0, "stopped");
        check(32'({int_seen, dma_seen}), 32'h0303, "interrupts and dma events");
        nmi_select = 1'b0;
        clear_flags(3'h2);
        wd_cfg = '{load_val: 16'h0001, prescale: 16'h0000};
        wd_enable = 1'b1;
        start_timer(2, 32'h0000_0001, 13'h0000, 1'b0);
        wd_enable = 1'b0;
        wait_flag(2);
        repeat (20) @(negedge clock);
        check(32'({pulses_seen, flags}), 32'h4, "general role never resets");
        clear_flags(3'h4);
        role = tw_pkg::TW_ROLE_WD;
        wd_cfg = '{load_val: 16'h0003, prescale: 16'h0001};
        start_timer(2, 32'h0000_0001, 13'h0000, 1'b0);
        check(32'(running), 32'h0, "start refused in watchdog role");
        wd_enable = 1'b1;
        @(negedge clock);
        wd_enable = 1'b0;
        check(32'(wd_count), 32'h0003, "watchdog loaded");
        service(10);
        check(32'({pulses_seen, wd_reset_n}), 32'h1, "serviced watchdog holds");
        n = 0;
        while (pulses_seen !== 8'h01 && n < 60) begin
            @(negedge clock);
            n++;
        end
        check(32'({pulses_seen, pulse_len}), 32'h010A, "reset pulse width");
        role = tw_pkg::TW_ROLE_BOTH;
        repeat (30) @(negedge clock);
        check(32'(pulses_seen), 32'h01, "watchdog disarmed after firing");
        start_timer(2, 32'h0000_0001, 13'h0000, 1'b0);
        wait_flag(2);
        check(32'(n), 32'h03, "third timer in both roles");
        start_timer(0, 32'h0000_0100, 13'h0000, 1'b0);
        rst = 1'b1;
        @(negedge clock);
        check(32'({running, flags, wd_reset_n}), 32'h1, "mid-run reset");
        rst = 1'b0;
        @(negedge clock);
        stop_test();
    end
endmodule // tb
